//--- rtl/uls_cfg.svh
/*
 * register map, field positions, reset values and bit timing
 * assumes: included by bare name from the uart line status files
 */
`ifndef ULS_CFG_SVH
`define ULS_CFG_SVH

// byte addresses on the register bus
`define ULS_RBR_ADDR     32'h40008000
`define ULS_FCR_ADDR     32'h40008008
`define ULS_LCR_ADDR     32'h4000800c
`define ULS_LSR_ADDR     32'h40008014

// line status field positions
`define ULS_FE_BIT       3
`define ULS_BI_BIT       4
`define ULS_TX_HOLDING_EMPTY_BIT     5
`define ULS_TX_ALL_EMPTY_BIT     6
`define ULS_RX_FIFO_ERR_FLAG_BIT     7

// reset values
`define ULS_TX_HOLDING_EMPTY_RST     1'b1
`define ULS_TX_ALL_EMPTY_RST     1'b1
`define ULS_FLAG_RST     1'b0
`define ULS_FCR_RST      2'h0
`define ULS_LCR_RST      2'h0

// fifo control and line control fields
`define ULS_FCR_EN_BIT   0
`define ULS_FCR_RST_BIT  1
`define ULS_LCR_PEN_BIT  0
`define ULS_LCR_ODD_BIT  1

// bit time (115200 baud) in ns and the clock period in ns
`define ULS_BIT_NS       8680
`define ULS_CLK_NS       8
`define ULS_BIT_CYC      (`ULS_BIT_NS / `ULS_CLK_NS)

`endif

//--- rtl/uls_pkg.sv
/*
 * types shared by the uart line status block
 * assumes: compiled before every uls module
 */
package uls_pkg;

   // one received character with its error marks
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } uls_char_type;

   // line format shared by receiver and transmitter
   typedef struct packed {
      logic podd;
      logic pen;
   } uls_line_cfg_type;

   typedef enum logic [5:0] {
      RX_IDLE  = 6'h01,
      RX_START = 6'h02,
      RX_DATA  = 6'h04,
      RX_PAR   = 6'h08,
      RX_STOP  = 6'h10,
      RX_BRKW  = 6'h20
   } uls_rx_state_type;

endpackage

//--- rtl/uls_rx.sv
/*
 * serial receiver: assembles characters, marks parity, framing, break
 * assumes: serial input already synchronous to ref_clk_i
 */
`timescale 1ns/10ps
`include "uls_cfg.svh"

module uls_rx
   import uls_pkg::*;
#(
   parameter int BIT_CYC = `ULS_BIT_CYC
)
(
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             serial_rx_input_i,
   input  wire uls_line_cfg_type cfg_i,
   output logic                  char_valid_o,
   output uls_char_type          char_o
);

   uls_rx_state_type state_reg, state_next;
   logic [15:0]      cnt_reg, cnt_next;
   logic [2:0]       idx_reg, idx_next;
   logic [7:0]       sh_reg, sh_next;
   logic             par_reg, par_next;
   logic             zero_reg, zero_next;
   logic             pe_reg, pe_next;
   logic             vld_next;
   uls_char_type     chr_next;
   logic             rx;

   assign rx = serial_rx_input_i;

   // bit sampler and character framing
   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      idx_next   = idx_reg;
      sh_next    = sh_reg;
      par_next   = par_reg;
      zero_next  = zero_reg;
      pe_next    = pe_reg;
      vld_next   = 1'b0;
      chr_next   = char_o;
      if (cnt_reg != 16'h0000)
         cnt_next = cnt_reg - 16'h0001;
      case (state_reg)
         RX_IDLE:
            if (!rx)
            begin
               state_next = RX_START;
               cnt_next   = 16'((BIT_CYC - 1) / 2);
            end
         RX_START:
            if (cnt_reg == 16'h0000)
            begin
               state_next = rx ? RX_IDLE : RX_DATA;
               cnt_next   = 16'(BIT_CYC - 1);
               idx_next   = 3'h0;
               zero_next  = 1'b1;
               par_next   = 1'b0;
               pe_next    = 1'b0;
            end
         RX_DATA:
            if (cnt_reg == 16'h0000)
            begin
               sh_next   = {rx, sh_reg[7:1]};
               par_next  = par_reg ^ rx;
               zero_next = zero_reg & ~rx;
               idx_next  = idx_reg + 3'h1;
               cnt_next  = 16'(BIT_CYC - 1);
               if (idx_reg == 3'h7)
                  state_next = cfg_i.pen ? RX_PAR : RX_STOP;
            end
         RX_PAR:
            if (cnt_reg == 16'h0000)
            begin
               pe_next    = par_reg ^ rx ^ cfg_i.podd;
               zero_next  = zero_reg & ~rx;
               cnt_next   = 16'(BIT_CYC - 1);
               state_next = RX_STOP;
            end
         RX_STOP:
            if (cnt_reg == 16'h0000)
            begin
               vld_next      = 1'b1;
               chr_next.data = sh_reg;
               chr_next.pe   = pe_reg;
               chr_next.fe   = ~rx;
               chr_next.brk  = ~rx & zero_reg;
               if (rx)
                  state_next = RX_IDLE;
               else if (zero_reg)
                  state_next = RX_BRKW;
               else
               begin
                  state_next = RX_DATA;
                  cnt_next   = 16'(BIT_CYC - 1);
                  idx_next   = 3'h0;
                  zero_next  = 1'b1;
                  par_next   = 1'b0;
                  pe_next    = 1'b0;
               end
            end
         RX_BRKW:
            if (rx)
               state_next = RX_IDLE;
         default:
            state_next = RX_IDLE;
      endcase
   end

   // receiver registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_reg    <= RX_IDLE;
         cnt_reg      <= 16'h0000;
         idx_reg      <= 3'h0;
         sh_reg       <= 8'h00;
         par_reg      <= 1'b0;
         zero_reg     <= 1'b0;
         pe_reg       <= 1'b0;
         char_valid_o <= 1'b0;
         char_o       <= '0;
      end
      else
      begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         idx_reg      <= idx_next;
         sh_reg       <= sh_next;
         par_reg      <= par_next;
         zero_reg     <= zero_next;
         pe_reg       <= pe_next;
         char_valid_o <= vld_next;
         char_o       <= chr_next;
      end
   end

endmodule

//--- rtl/uls_top.sv
/*
 * uart line status block: receive fifo, line status flags, bus slave
 * assumes: avalon-mm master with waitrequest, serial input synchronous
 */
`timescale 1ns/10ps
`include "uls_cfg.svh"

module uls_top
   import uls_pkg::*;
#(
   parameter int DEPTH   = 16,
   parameter int BIT_CYC = `ULS_BIT_CYC
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic [31:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        serial_rx_input_i,
   output logic             serial_tx_o
);

   localparam int AW = $clog2(DEPTH);

   // bus slave state
   logic             ack_reg, ack_next;
   logic [31:0]      rdata_next;
   logic             rd_acc, wr_acc;
   logic             rbr_rd, lsr_rd, thr_wr, fcr_wr, lcr_wr;

   // control registers
   logic [1:0]       fcr_reg, fcr_next;
   uls_line_cfg_type lcr_reg, lcr_next;
   logic             fifo_en, flush;

   // receive path
   logic             rx_vld;
   uls_char_type     rx_chr;
   uls_char_type     mem [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      cnt_reg, cnt_next, cap;
   logic [AW:0]      ecnt_reg, ecnt_next;
   logic             push, pop, head_new;
   uls_char_type     head, head_in;

   // status flags
   logic             fe_reg, fe_next;
   logic             bi_reg, bi_next;
   logic             rx_fifo_err_flag_reg, rx_fifo_err_flag_next;
   logic             tx_holding_empty_reg, tx_holding_empty_next;
   logic             tx_all_empty_reg, tx_all_empty_next;
   logic             hold_mt_d_reg;
   logic             hold_mt, shift_mt;
   logic [7:0]       lsr_val;

   // errored character test, used on the pushed character and on the head at a pop
   function automatic logic has_err(input uls_char_type c);
      has_err = c.fe | c.pe | c.brk;
   endfunction

   uls_rx #(
      .BIT_CYC (BIT_CYC)
   ) u_rx (
      .ref_clk_i         (ref_clk_i),
      .rst_b_i           (rst_b_i),
      .serial_rx_input_i (serial_rx_input_i),
      .cfg_i             (lcr_reg),
      .char_valid_o      (rx_vld),
      .char_o            (rx_chr)
   );

   uls_tx #(
      .BIT_CYC (BIT_CYC)
   ) u_tx (
      .ref_clk_i     (ref_clk_i),
      .rst_b_i       (rst_b_i),
      .wr_i          (thr_wr),
      .wr_data_i     (avs_writedata_i[7:0]),
      .cfg_i         (lcr_reg),
      .serial_tx_o   (serial_tx_o),
      .hold_empty_o  (hold_mt),
      .shift_empty_o (shift_mt)
   );

   // request held one cycle, answered on the second edge
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
   assign rd_acc = avs_read_i & ack_reg;
   assign wr_acc = avs_write_i & ack_reg;

   // address decode of accepted accesses
   assign rbr_rd = rd_acc & (avs_address_i == `ULS_RBR_ADDR);
   assign lsr_rd = rd_acc & (avs_address_i == `ULS_LSR_ADDR);
   assign thr_wr = wr_acc & (avs_address_i == `ULS_RBR_ADDR);
   assign fcr_wr = wr_acc & (avs_address_i == `ULS_FCR_ADDR);
   assign lcr_wr = wr_acc & (avs_address_i == `ULS_LCR_ADDR);

   // line status value as seen by software
   always_comb
   begin
      lsr_val                = 8'h00;
      lsr_val[`ULS_FE_BIT]   = fe_reg;
      lsr_val[`ULS_BI_BIT]   = bi_reg;
      lsr_val[`ULS_TX_HOLDING_EMPTY_BIT] = tx_holding_empty_reg;
      lsr_val[`ULS_TX_ALL_EMPTY_BIT] = tx_all_empty_reg;
      lsr_val[`ULS_RX_FIFO_ERR_FLAG_BIT] = rx_fifo_err_flag_reg & fifo_en;
   end

   // read data capture on the first cycle of a read
   always_comb
   begin
      ack_next   = (avs_read_i | avs_write_i) & ~ack_reg;
      rdata_next = avs_readdata_o;
      if (avs_read_i && !ack_reg)
      begin
         rdata_next = 32'h0000_0000;
         case (avs_address_i)
            `ULS_RBR_ADDR:
               rdata_next[7:0] = (cnt_reg != '0) ? head.data : 8'h00;
            `ULS_FCR_ADDR:
               rdata_next[0]   = fcr_reg[`ULS_FCR_EN_BIT];
            `ULS_LCR_ADDR:
               rdata_next[1:0] = lcr_reg;
            `ULS_LSR_ADDR:
               rdata_next[7:0] = lsr_val;
            default:
               rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         ack_reg        <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
      end
      else
      begin
         ack_reg        <= ack_next;
         avs_readdata_o <= rdata_next;
      end
   end

   // fifo and line control; reset bit self clears
   always_comb
   begin
      fcr_next = fcr_reg;
      lcr_next = lcr_reg;
      fcr_next[`ULS_FCR_RST_BIT] = 1'b0;
      if (fcr_wr)
         fcr_next = avs_writedata_i[1:0];
      if (lcr_wr)
      begin
         lcr_next.pen  = avs_writedata_i[`ULS_LCR_PEN_BIT];
         lcr_next.podd = avs_writedata_i[`ULS_LCR_ODD_BIT];
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fcr_reg <= `ULS_FCR_RST;
         lcr_reg <= `ULS_LCR_RST;
      end
      else
      begin
         fcr_reg <= fcr_next;
         lcr_reg <= lcr_next;
      end
   end

   assign fifo_en = fcr_reg[`ULS_FCR_EN_BIT];
   // flush on reset request or on a change of fifo mode
   assign flush = fcr_reg[`ULS_FCR_RST_BIT] |
                  (fcr_wr & (avs_writedata_i[0] != fifo_en));

   assign cap  = fifo_en ? (AW+1)'(DEPTH) : (AW+1)'(1);
   assign push = rx_vld & (cnt_reg < cap) & ~flush;
   assign pop  = rbr_rd & (cnt_reg != '0) & ~flush;
   assign head = mem[rp_reg];

   always_comb
   begin
      head_new = 1'b0;
      head_in  = head;
      if (!flush)
      begin
         if (pop && cnt_reg > (AW+1)'(1))
         begin
            head_new = 1'b1;
            head_in  = mem[AW'(rp_reg + AW'(1))];
         end
         else if (push && (cnt_reg == '0 || pop))
         begin
            head_new = 1'b1;
            head_in  = rx_chr;
         end
      end
   end

   // pointers, fill level and count of errored entries
   always_comb
   begin
      wp_next   = wp_reg;
      rp_next   = rp_reg;
      cnt_next  = cnt_reg;
      ecnt_next = ecnt_reg;
      if (flush)
      begin
         wp_next   = '0;
         rp_next   = '0;
         cnt_next  = '0;
         ecnt_next = '0;
      end
      else
      begin
         if (push)
            wp_next = (wp_reg == AW'(DEPTH - 1)) ? '0 : AW'(wp_reg + AW'(1));
         if (pop)
            rp_next = (rp_reg == AW'(DEPTH - 1)) ? '0 : AW'(rp_reg + AW'(1));
         cnt_next  = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
         ecnt_next = ecnt_reg + (AW+1)'(push & has_err(rx_chr))
                              - (AW+1)'(pop & has_err(head));
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         wp_reg   <= '0;
         rp_reg   <= '0;
         cnt_reg  <= '0;
         ecnt_reg <= '0;
      end
      else
      begin
         wp_reg   <= wp_next;
         rp_reg   <= rp_next;
         cnt_reg  <= cnt_next;
         ecnt_reg <= ecnt_next;
      end
   end

   // character storage
   always_ff @(posedge ref_clk_i)
   begin
      if (push)
         mem[wp_reg] <= rx_chr;
   end

   // sticky flags; fe and bi clear only if the read returned them, the fifo error flag at a status read once no errored entry remains
   always_comb
   begin
      fe_next   = fe_reg;
      bi_next   = bi_reg;
      rx_fifo_err_flag_next = rx_fifo_err_flag_reg;
      if (lsr_rd && avs_readdata_o[`ULS_FE_BIT])
         fe_next = 1'b0;
      if (lsr_rd && avs_readdata_o[`ULS_BI_BIT])
         bi_next = 1'b0;
      if (lsr_rd && ecnt_next == '0)
         rx_fifo_err_flag_next = 1'b0;
      if (head_new && head_in.fe)
         fe_next = 1'b1;
      if (head_new && head_in.brk)
         bi_next = 1'b1;
      if (push && has_err(rx_chr))
         rx_fifo_err_flag_next = 1'b1;
      if (flush)
         rx_fifo_err_flag_next = 1'b0;
   end

   // transmit status flags
   always_comb
   begin
      tx_holding_empty_next = tx_holding_empty_reg;
      if (thr_wr)
         tx_holding_empty_next = 1'b0;
      if (hold_mt && !hold_mt_d_reg)
         tx_holding_empty_next = 1'b1;
      tx_all_empty_next = hold_mt & shift_mt & ~thr_wr;
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         fe_reg        <= `ULS_FLAG_RST;
         bi_reg        <= `ULS_FLAG_RST;
         rx_fifo_err_flag_reg      <= `ULS_FLAG_RST;
         tx_holding_empty_reg      <= `ULS_TX_HOLDING_EMPTY_RST;
         tx_all_empty_reg      <= `ULS_TX_ALL_EMPTY_RST;
         hold_mt_d_reg <= 1'b1;
      end
      else
      begin
         fe_reg        <= fe_next;
         bi_reg        <= bi_next;
         rx_fifo_err_flag_reg      <= rx_fifo_err_flag_next;
         tx_holding_empty_reg      <= tx_holding_empty_next;
         tx_all_empty_reg      <= tx_all_empty_next;
         hold_mt_d_reg <= hold_mt;
      end
   end

endmodule

//--- rtl/uls_tx.sv
/*
 * transmitter: holding register feeding a shift register
 * assumes: one write strobe per accepted bus write
 */
`timescale 1ns/10ps
`include "uls_cfg.svh"

module uls_tx
   import uls_pkg::*;
#(
   parameter int BIT_CYC = `ULS_BIT_CYC
)
(
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             wr_i,
   input  wire logic [7:0]       wr_data_i,
   input  wire uls_line_cfg_type cfg_i,
   output logic                  serial_tx_o,
   output logic                  hold_empty_o,
   output logic                  shift_empty_o
);

   logic [7:0]  hold_reg, hold_next;
   logic        full_reg, full_next;
   logic [10:0] sh_reg, sh_next;
   logic [3:0]  left_reg, left_next;
   logic [15:0] cnt_reg, cnt_next;

   // load holding register, move it to the shifter, send bits
   always_comb
   begin
      hold_next = hold_reg;
      full_next = full_reg;
      sh_next   = sh_reg;
      left_next = left_reg;
      cnt_next  = cnt_reg;
      if (left_reg != 4'h0)
      begin
         if (cnt_reg != 16'h0000)
            cnt_next = cnt_reg - 16'h0001;
         else
         begin
            sh_next   = {1'b1, sh_reg[10:1]};
            left_next = left_reg - 4'h1;
            cnt_next  = 16'(BIT_CYC - 1);
         end
      end
      else if (full_reg)
      begin
         sh_next   = {1'b1, ^hold_reg ^ cfg_i.podd, hold_reg, 1'b0};
         if (!cfg_i.pen)
            sh_next[9] = 1'b1;
         left_next = cfg_i.pen ? 4'hb : 4'ha;
         cnt_next  = 16'(BIT_CYC - 1);
         full_next = 1'b0;
      end
      if (wr_i)
      begin
         hold_next = wr_data_i;   // a write to a full holding overwrites
         full_next = 1'b1;
      end
   end

   // transmitter registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         hold_reg <= 8'h00;
         full_reg <= 1'b0;
         sh_reg   <= 11'h7ff;
         left_reg <= 4'h0;
         cnt_reg  <= 16'h0000;
      end
      else
      begin
         hold_reg <= hold_next;
         full_reg <= full_next;
         sh_reg   <= sh_next;
         left_reg <= left_next;
         cnt_reg  <= cnt_next;
      end
   end

   assign serial_tx_o   = (left_reg == 4'h0) ? 1'b1 : sh_reg[0];
   assign hold_empty_o  = ~full_reg;
   assign shift_empty_o = (left_reg == 4'h0);

endmodule

//--- tb/tb_top.sv
/* self-checking bench for uls_top
   assumes: uls_rtx partner on the receive line, checker bound */
`timescale 1ns/10ps
`include "uls_cfg.svh"
module tb_top;
   localparam int BC = 8;
   localparam logic [31:0] LSR = `ULS_LSR_ADDR;
   localparam logic [31:0] RBR = `ULS_RBR_ADDR;
   localparam logic [31:0] FCR = `ULS_FCR_ADDR;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i   = 1'b0;
   logic [31:0] adr       = 32'h0;
   logic [31:0] wd        = 32'h0;
   logic        rd        = 1'b0;
   logic        wr        = 1'b0;
   logic        go        = 1'b0;
   logic [15:0] frm       = 16'hffff;
   logic [4:0]  len       = 5'h0;
   logic [31:0] rdat;
   logic        wreq;
   logic        rxd;
   logic        txd;
   logic        busy;
   logic [7:0]  d;
   logic [31:0] exp_q[$];
   int          err_total = 0;
   int          checked   = 0;
   int          cyc       = 0;

   always #4 ref_clk_i = ~ref_clk_i;

   uls_top #(.DEPTH(16), .BIT_CYC(BC)) DUT (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
      .serial_rx_input_i(rxd), .serial_tx_o(txd));
   uls_rtx #(.BIT_CYC(BC)) peer (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .go_i(go),
      .frame_i(frm), .len_i(len), .serial_o(rxd), .busy_o(busy));

   task check_val(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, seen, want);
      end
   endtask

   task print_verdict;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // one bus cycle, held until waitrequest is sampled low at a rising edge
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] v);
      @(posedge ref_clk_i);
      adr <= a;
      wd  <= v;
      rd  <= !w;
      wr  <= w;
      @(posedge ref_clk_i);
      while (wreq)
         @(posedge ref_clk_i);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task rdx(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask

   task send(input logic [15:0] f, input logic [4:0] n);
      @(posedge ref_clk_i);
      frm <= f;
      len <= n;
      go  <= 1'b1;
      @(posedge ref_clk_i);
      go <= 1'b0;
      @(negedge ref_clk_i);
      while (busy)
         @(negedge ref_clk_i);
   endtask

   task bits(input int n);
      repeat (n * BC) @(posedge ref_clk_i);
   endtask

   // drain an errored head: flags, then fifo error, then idle
   task err_seq(input logic [31:0] first, input logic [31:0] v);
      rdx(LSR, first);
      rdx(LSR, 32'he0);
      rdx(RBR, v);
      rdx(LSR, 32'he0);
      rdx(LSR, 32'h60);
   endtask

   // compare each accepted read with the oldest note, at the accepting edge
   always @(posedge ref_clk_i)
      if (rd && !wreq && exp_q.size() > 0)
         check_val(rdat, exp_q.pop_front());

   // hang guard
   always @(posedge ref_clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_total++;
         print_verdict;
      end
   end

   initial
   begin
      void'($urandom(11));
      repeat (16) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      rdx(LSR, 32'h60);
      rdx(32'h40008030, 32'h0);
      xfer(1'b1, 32'h40008030, 32'hffffffff);
      xfer(1'b1, FCR, 32'h1);
      rdx(FCR, 32'h1);
      $display("test reset done");
      repeat (3)
      begin
         d = 8'($urandom);
         send({6'h3f, 1'b1, d, 1'b0}, 5'd10);
         bits(2);
         rdx(LSR, 32'h60);
         rdx(RBR, {24'h0, d});
      end
      $display("test clean done");
      send({6'h3f, 1'b0, 8'h3c, 1'b0}, 5'd10);
      bits(11);
      err_seq(32'he8, 32'h3c);
      rdx(RBR, 32'hff);
      $display("test framing done");
      send(16'h0, 5'd12);
      bits(2);
      err_seq(32'hf8, 32'h0);
      bits(4);
      rdx(RBR, 32'h0);
      $display("test break done");
      xfer(1'b1, `ULS_LCR_ADDR, 32'h1);
      send({5'h1f, 1'b1, 1'b0, 8'h01, 1'b0}, 5'd11);
      bits(2);
      err_seq(32'he0, 32'h01);
      // odd parity: same frame now carries a correct parity bit
      xfer(1'b1, `ULS_LCR_ADDR, 32'h3);
      send({5'h1f, 1'b1, 1'b0, 8'h01, 1'b0}, 5'd11);
      bits(2);
      rdx(LSR, 32'h60);
      rdx(RBR, 32'h01);
      xfer(1'b1, `ULS_LCR_ADDR, 32'h0);
      $display("test parity done");
      d = 8'($urandom);
      xfer(1'b1, RBR, {24'h0, d});
      xfer(1'b1, RBR, {24'h0, ~d});
      rdx(LSR, 32'h0);
      bits(12);
      rdx(LSR, 32'h20);
      bits(12);
      rdx(LSR, 32'h60);
      $display("test transmit done");
      xfer(1'b1, FCR, 32'h0);
      send({6'h3f, 1'b0, 8'h3c, 1'b0}, 5'd10);
      bits(11);
      rdx(LSR, 32'h68);
      rdx(LSR, 32'h60);
      rdx(RBR, 32'h3c);
      rdx(RBR, 32'h0);
      $display("test fifo off done");
      // fifo back on, one clean character, then the self clearing reset
      xfer(1'b1, FCR, 32'h1);
      d = 8'($urandom);
      send({6'h3f, 1'b1, d, 1'b0}, 5'd10);
      bits(2);
      xfer(1'b1, FCR, 32'h3);
      rdx(FCR, 32'h1);
      rdx(RBR, 32'h0);
      $display("test fifo reset done");
      bits(1);
      print_verdict;
   end
endmodule

//--- tb/uls_properties.sv
/* concurrent checks on the uls_top ports
   assumes: bound into uls_top, one clock domain */
`timescale 1ns/10ps
`include "uls_cfg.svh"
module uls_chk
#(
   parameter int DEPTH   = 16,
   parameter int BIT_CYC = 8
)
(
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   input wire logic [31:0] avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        serial_rx_input_i,
   input wire logic        serial_tx_o
);
   logic lsr_acc;
   logic wr_acc;
   logic en_reg;
   logic en_next;
   logic fresh_reg;
   logic fresh_next;

   // accepted status read and accepted write
   assign lsr_acc = avs_read_i && !avs_waitrequest_o
                    && (avs_address_i == `ULS_LSR_ADDR);
   assign wr_acc  = avs_write_i && !avs_waitrequest_o;

   // track fifo enable and the untouched state after reset
   always_comb
   begin
      en_next    = en_reg;
      fresh_next = fresh_reg && serial_rx_input_i;
      if (wr_acc && avs_address_i == `ULS_FCR_ADDR)
         en_next = avs_writedata_i[0];
      if (wr_acc && avs_address_i == `ULS_RBR_ADDR)
         fresh_next = 1'b0;
   end

   // helper registers
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         en_reg    <= 1'b0;
         fresh_reg <= 1'b1;
      end
      else
      begin
         en_reg    <= en_next;
         fresh_reg <= fresh_next;
      end
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_RSV_ZERO: assert property (avs_read_i && !avs_waitrequest_o
      |-> avs_readdata_o[31:8] == 24'h0) else $error("upper bits set");
   AST_FE_CLR: assert property (lsr_acc && avs_readdata_o[3]
      ##[2:3] lsr_acc |-> !avs_readdata_o[3]) else $error("fe kept");
   AST_BI_CLR: assert property (lsr_acc && avs_readdata_o[4]
      ##[2:3] lsr_acc |-> !avs_readdata_o[4]) else $error("bi kept");
   AST_RX_FIFO_ERR_FLAG_OFF: assert property (lsr_acc && !en_reg
      |-> !avs_readdata_o[7]) else $error("rx_fifo_err_flag with fifo off");
   AST_BI_FE: assert property (lsr_acc && avs_readdata_o[4]
      |-> avs_readdata_o[3]) else $error("break without fe");
   AST_TX_ALL_EMPTY_TX_HOLDING_EMPTY: assert property (lsr_acc && avs_readdata_o[6]
      |-> avs_readdata_o[5]) else $error("tx_all_empty without tx_holding_empty");
   AST_TX_ALL_EMPTY_LINE: assert property (lsr_acc && !serial_tx_o
      |-> !avs_readdata_o[6]) else $error("tx_all_empty while sending");
   AST_ERR_RX_FIFO_ERR_FLAG: assert property (lsr_acc && en_reg
      && (avs_readdata_o[3] || avs_readdata_o[4]) |-> avs_readdata_o[7])
      else $error("head error without rx_fifo_err_flag");
   AST_RST_VAL: assert property (lsr_acc && fresh_reg
      |-> avs_readdata_o[7:3] == 5'h0c) else $error("bad idle status");
   AST_ONE_WAIT: assert property ((avs_read_i || avs_write_i)
      && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait long");
endmodule

bind uls_top uls_chk #(.DEPTH(DEPTH), .BIT_CYC(BIT_CYC)) chk (
   .ref_clk_i         (ref_clk_i),
   .rst_b_i           (rst_b_i),
   .avs_address_i     (avs_address_i),
   .avs_read_i        (avs_read_i),
   .avs_write_i       (avs_write_i),
   .avs_writedata_i   (avs_writedata_i),
   .avs_readdata_o    (avs_readdata_o),
   .avs_waitrequest_o (avs_waitrequest_o),
   .serial_rx_input_i (serial_rx_input_i),
   .serial_tx_o       (serial_tx_o)
);

//--- tb/uls_rtx.sv
/* remote serial transmitter driving the receive line of uls_top
   assumes: one frame per go pulse, line idles high between frames */
`timescale 1ns/10ps
module uls_rtx
#(
   parameter int BIT_CYC = 8
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        go_i,
   input  wire logic [15:0] frame_i,
   input  wire logic [4:0]  len_i,
   output logic             serial_o,
   output logic             busy_o
);
   logic [15:0] sh_reg;
   logic [4:0]  left_reg;
   int          cnt_reg;

   // shift the frame out lsb first, one bit per bit time
   always_ff @(posedge ref_clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         sh_reg   <= 16'hffff;
         left_reg <= 5'h0;
         cnt_reg  <= 0;
      end
      else if (go_i && left_reg == 5'h0)
      begin
         sh_reg   <= frame_i;
         left_reg <= len_i;
         cnt_reg  <= BIT_CYC - 1;
      end
      else if (left_reg != 5'h0 && cnt_reg == 0)
      begin
         sh_reg   <= {1'b1, sh_reg[15:1]};
         left_reg <= left_reg - 5'h1;
         cnt_reg  <= BIT_CYC - 1;
      end
      else if (left_reg != 5'h0)
         cnt_reg <= cnt_reg - 1;
   end

   // released line rests at the marking level
   assign serial_o = (left_reg != 5'h0) ? sh_reg[0] : 1'b1;
   assign busy_o   = (left_reg != 5'h0);
endmodule
